// ==== mbfc_codec.sv ====
// Serial frame codec: transmit framer with a 16-word buffer and status
// point packer, and a receive checker for binary and hex-text framing.
// Assumes the character source and sink (a UART) run on mclk_in and that
// char_tick_in pulses once per character time.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, flip-flop storage
module mbfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              wr = in_valid_in & in_ready_out;
  wire              rd = out_valid_out & out_ready_in;

  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign next_count    = count + (AW+1)'(wr) - (AW+1)'(rd);

  // Ready is registered from the next fill level, so it never over-promises
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      in_ready_out <= 1'b1;
    end
    else
    begin
      wr_ptr       <= wr ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr       <= rd ? rd_ptr + 1'b1 : rd_ptr;
      count        <= next_count;
      in_ready_out <= (next_count < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (wr)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mbfc_codec
  import mbfc_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  input  wire logic               ascii_mode_in,
  input  wire logic               resp_mode_in,
  input  wire logic [7:0]         station_addr_in,
  input  wire logic               tx_valid_in,
  input  wire mbfc_tx_item_type   tx_item_in,
  output logic                    tx_ready_out,
  output logic [7:0]              tx_char_out,
  output logic                    tx_char_valid_out,
  input  wire logic               tx_char_ready_in,
  input  wire logic [7:0]         rx_char_in,
  input  wire logic               rx_char_valid_in,
  input  wire logic               char_tick_in,
  output logic [7:0]              rx_byte_out,
  output logic                    rx_byte_valid_out,
  output logic                    rx_done_out,
  output mbfc_rx_status_type      rx_status_out,
  output logic [9:0]              rx_expect_len_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Status point packer in front of the buffer
  logic [7:0]       pack_reg;
  logic [2:0]       pack_cnt;
  wire              item_take  = tx_valid_in & tx_ready_out;
  wire  [7:0]       pack_next  = pack_reg | (8'(tx_item_in.data[0]) << pack_cnt);
  wire              pack_flush = tx_item_in.pack_end | (pack_cnt == PACK_LAST);
  wire              fifo_wr    = item_take & (~tx_item_in.is_bit | pack_flush);
  wire  [8:0]       fifo_wdata = {tx_item_in.last,
                                  tx_item_in.is_bit ? pack_next : tx_item_in.data};
  wire              fifo_valid;
  wire  [8:0]       fifo_rdata;
  logic             fifo_pop;

  // Register cleared on each flush, so unused high bits go out as zero
  always_ff @(posedge mclk_in)
  begin
    if (rst_in | (item_take & tx_item_in.is_bit & pack_flush))
    begin
      pack_reg <= 8'h00;
      pack_cnt <= 3'h0;
    end
    else if (item_take & tx_item_in.is_bit)
    begin
      pack_reg <= pack_next;
      pack_cnt <= pack_cnt + 3'h1;
    end
  end

  mbfc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (fifo_wr),
    .in_data_in    (fifo_wdata),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_rdata),
    .out_ready_in  (fifo_pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmit framer
  mbfc_tx_state_type tx_state;
  mbfc_tx_state_type next_tx_state;
  logic              tx_idx;
  logic              next_tx_idx;
  logic [15:0]       tx_crc;
  logic [15:0]       next_tx_crc;
  logic [7:0]        tx_lrc;
  logic [7:0]        next_tx_lrc;
  logic              emit;
  logic [7:0]        emit_char;
  wire               slot    = ~tx_char_valid_out | tx_char_ready_in;
  wire  [7:0]        tx_byte = fifo_rdata[7:0];
  wire  [7:0]        lrc_neg = 8'h00 - tx_lrc;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_idx   = tx_idx;
    next_tx_crc   = tx_crc;
    next_tx_lrc   = tx_lrc;
    emit          = 1'b0;
    emit_char     = 8'h00;
    fifo_pop      = 1'b0;
    case (tx_state)
      T_IDLE:
        if (slot & fifo_valid)
        begin
          next_tx_crc   = CRC_INIT;
          next_tx_lrc   = LRC_INIT;
          next_tx_idx   = 1'b0;
          next_tx_state = T_BODY;
          emit          = ascii_mode_in;
          emit_char     = CH_COLON;
        end
      T_BODY:
        if (slot & fifo_valid)
        begin
          emit = 1'b1;
          if (ascii_mode_in)
          begin
            emit_char   = mbfc_hex_char(tx_idx ? tx_byte[3:0] : tx_byte[7:4]);
            fifo_pop    = tx_idx;
            next_tx_lrc = tx_idx ? tx_lrc + tx_byte : tx_lrc;
            next_tx_idx = ~tx_idx;
          end
          else
          begin
            emit_char   = tx_byte;
            fifo_pop    = 1'b1;
            next_tx_crc = mbfc_crc_byte(tx_crc, tx_byte);
          end
          if (fifo_pop & fifo_rdata[8])
          begin
            next_tx_state = T_CHK;
            next_tx_idx   = 1'b0;
          end
        end
      T_CHK:
        if (slot)
        begin
          emit        = 1'b1;
          next_tx_idx = ~tx_idx;
          // Check field closes the content
          if (ascii_mode_in)
            emit_char = mbfc_hex_char(tx_idx ? lrc_neg[3:0] : lrc_neg[7:4]);
          else
            emit_char = tx_idx ? tx_crc[15:8] : tx_crc[7:0];
          if (tx_idx)
            next_tx_state = ascii_mode_in ? T_TAIL : T_IDLE;
        end
      default:
        if (slot)
        begin
          emit        = 1'b1;
          emit_char   = tx_idx ? CH_LF : CH_CR;
          next_tx_idx = ~tx_idx;
          if (tx_idx)
            next_tx_state = T_IDLE;
        end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      tx_state          <= T_IDLE;
      tx_idx            <= 1'b0;
      tx_crc            <= CRC_INIT;
      tx_lrc            <= LRC_INIT;
      tx_char_out       <= 8'h00;
      tx_char_valid_out <= 1'b0;
    end
    else
    begin
      tx_state          <= next_tx_state;
      tx_idx            <= next_tx_idx;
      tx_crc            <= next_tx_crc;
      tx_lrc            <= next_tx_lrc;
      tx_char_out       <= emit ? emit_char : tx_char_out;
      tx_char_valid_out <= emit | (tx_char_valid_out & ~tx_char_ready_in);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive checker
  mbfc_rx_state_type rx_state;
  logic              rx_nib;
  logic [3:0]        rx_hi;
  logic [8:0]        rx_cnt;
  logic [15:0]       rx_crc;
  logic [7:0]        rx_lrc;
  logic [7:0]        rx_addr;
  logic [7:0]        rx_fc;
  logic [7:0]        rx_bc;
  logic [2:0]        rx_gap;
  logic              rx_herr;
  logic [7:0]        pipe_new;
  logic [7:0]        pipe_old;
  logic [1:0]        pipe_cnt;

  wire       c        = rx_char_valid_in;
  wire       is_colon = (rx_char_in == CH_COLON);
  wire       is_cr    = (rx_char_in == CH_CR);
  wire       is_digit = (rx_char_in >= 8'h30) & (rx_char_in <= 8'h39);
  wire       is_upper = (rx_char_in >= 8'h41) & (rx_char_in <= 8'h46);
  wire       is_lower = (rx_char_in >= 8'h61) & (rx_char_in <= 8'h66);
  wire       hex_ok   = is_digit | is_upper | is_lower;
  wire [7:0] hex_sub  = is_digit ? HEX_DIGIT_OFS : (is_upper ? HEX_ALPHA_OFS : HEX_LOWER_OFS);
  wire [7:0] hex_full = rx_char_in - hex_sub;
  wire [3:0] hex_val  = hex_full[3:0];
  wire       in_body  = (rx_state == R_BODY);

  wire       a_start  = ascii_mode_in & c & is_colon;
  wire       r_start  = ~ascii_mode_in & c & (rx_state == R_IDLE);
  wire       a_char   = ascii_mode_in & c & in_body & ~is_colon;
  wire       a_hex    = a_char & ~is_cr & hex_ok;
  wire       got_byte = r_start | (~ascii_mode_in & c & in_body) | (a_hex & rx_nib);
  wire [7:0] byte_val = ascii_mode_in ? {rx_hi, hex_val} : rx_char_in;
  wire       a_cr     = a_char & is_cr;
  wire       a_bad    = (a_char & ~is_cr & ~hex_ok) | (a_cr & rx_nib);
  // Frame ends after more than three idle character times
  wire       r_end    = ~ascii_mode_in & in_body & char_tick_in & ~c &
                        (rx_gap == GAP_TICKS - 3'h1);
  wire       a_end    = ascii_mode_in & c & (rx_state == R_LF) & ~is_colon;
  wire       f_end    = r_end | a_end;

  wire [15:0] crc_base = r_start ? CRC_INIT : rx_crc;
  wire [8:0]  cnt_base = r_start ? POS_ADDR : rx_cnt;
  wire [8:0]  chk_len  = ascii_mode_in ? LRC_LEN : CRC_LEN;
  wire [8:0]  bc_pos   = resp_mode_in ? POS_BC_RESP : POS_BC_QUERY;

  // Expected length from function code and direction
  wire        fc_rd    = (rx_fc >= FC_RD_COILS) & (rx_fc <= FC_RD_INREGS);
  wire        fc_wr1   = (rx_fc == FC_WR_COIL) | (rx_fc == FC_WR_REG);
  wire        fc_wrm   = (rx_fc == FC_WR_COILS) | (rx_fc == FC_WR_REGS);
  wire        exc      = rx_fc[7];
  wire        exp_known = exc | fc_rd | fc_wr1 | fc_wrm;
  wire [8:0]  exp_body = exc ? BODY_EXC :
                         resp_mode_in ? (fc_rd ? BODY_RD_RESP + {1'b0, rx_bc} : BODY_FIXED) :
                         (fc_wrm ? BODY_MULTI_Q + {1'b0, rx_bc} : BODY_FIXED);
  wire [8:0]  exp_bin  = exp_body + CRC_LEN;
  wire        len_ok   = ~exp_known | (rx_cnt == exp_body + chk_len);
  // Running check over content plus received check comes to zero
  wire        sum_ok   = ascii_mode_in ? (rx_lrc == 8'h00) : (rx_crc == 16'h0000);
  wire        good     = sum_ok & len_ok & ~rx_herr & (~ascii_mode_in | (rx_char_in == CH_LF));
  wire        addr_ok  = (rx_addr != ADDR_BCAST) & (rx_addr <= ADDR_MAX);
  wire        pipe_full = ({7'h00, pipe_cnt} >= chk_len);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rx_state <= R_IDLE;
    else if (a_start | r_start)
      rx_state <= R_BODY;
    else if (a_cr)
      rx_state <= R_LF;
    else if (f_end)
      rx_state <= R_IDLE;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in | a_start | r_start)
    begin
      rx_nib  <= 1'b0;
      rx_lrc  <= LRC_INIT;
      rx_herr <= 1'b0;
    end
    else
    begin
      rx_nib  <= a_hex ? ~rx_nib : rx_nib;
      rx_lrc  <= (got_byte & ascii_mode_in) ? rx_lrc + byte_val : rx_lrc;
      rx_herr <= rx_herr | a_bad;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rx_hi  <= 4'h0;
      rx_cnt <= POS_ADDR;
      rx_crc <= CRC_INIT;
      rx_gap <= 3'h0;
    end
    else
    begin
      rx_hi  <= (a_hex & ~rx_nib) ? hex_val : rx_hi;
      rx_cnt <= a_start ? POS_ADDR : (got_byte ? cnt_base + 9'h001 : rx_cnt);
      rx_crc <= got_byte ? mbfc_crc_byte(crc_base, byte_val) : rx_crc;
      rx_gap <= c ? 3'h0 : (char_tick_in ? rx_gap + 3'h1 : rx_gap);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rx_addr <= ADDR_BCAST;
      rx_fc   <= 8'h00;
      rx_bc   <= 8'h00;
    end
    else if (got_byte)
    begin
      rx_addr <= (cnt_base == POS_ADDR) ? byte_val : rx_addr;
      rx_fc   <= (cnt_base == POS_FC) ? byte_val : rx_fc;
      rx_bc   <= (cnt_base == bc_pos) ? byte_val : rx_bc;
    end
  end

  // Bytes are held back by the check length so check bytes never surface
  always_ff @(posedge mclk_in)
  begin
    if (rst_in | f_end | a_start)
      pipe_cnt <= 2'h0;
    else if (got_byte & ~pipe_full)
      pipe_cnt <= pipe_cnt + 2'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pipe_new          <= 8'h00;
      pipe_old          <= 8'h00;
      rx_byte_out       <= 8'h00;
      rx_byte_valid_out <= 1'b0;
    end
    else
    begin
      pipe_new          <= got_byte ? byte_val : pipe_new;
      pipe_old          <= got_byte ? pipe_new : pipe_old;
      rx_byte_out       <= ascii_mode_in ? pipe_new : pipe_old;
      rx_byte_valid_out <= got_byte & pipe_full & ~r_start;
    end
  end

  // Bad frames raise error and never ask for a reply
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rx_done_out       <= 1'b0;
      rx_status_out     <= '0;
      rx_expect_len_out <= 10'h000;
    end
    else
    begin
      rx_done_out       <= f_end;
      rx_expect_len_out <= ascii_mode_in ? {exp_bin, 1'b1} : {1'b0, exp_bin};
      if (f_end)
      begin
        rx_status_out.ok        <= good;
        rx_status_out.error     <= ~good;
        rx_status_out.exception <= exc;
        rx_status_out.broadcast <= (rx_addr == ADDR_BCAST);
        rx_status_out.respond   <= good & ~resp_mode_in & addr_ok &
                                   (rx_addr == station_addr_in);
      end
    end
  end
endmodule

// ==== mbfc_pkg.sv ====
// Shared constants, carriers and helpers for the serial frame codec.
// Assumes one 10 MHz clock domain and a byte-wide character source/sink.
package mbfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Checksum and character constants
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV  = 16'ha001;  // x16+x15+x2+1, bit reversed
  localparam logic [7:0]  LRC_INIT      = 8'h00;
  localparam logic [7:0]  CH_COLON      = 8'h3a;
  localparam logic [7:0]  CH_CR         = 8'h0d;
  localparam logic [7:0]  CH_LF         = 8'h0a;
  localparam logic [7:0]  HEX_DIGIT_OFS = 8'h30;
  localparam logic [7:0]  HEX_ALPHA_OFS = 8'h37;
  localparam logic [7:0]  HEX_LOWER_OFS = 8'h57;
  localparam logic [7:0]  ADDR_BCAST    = 8'h00;
  localparam logic [7:0]  ADDR_MAX      = 8'hf7;
  // Idle character times that end a binary frame (more than three)
  localparam logic [2:0]  GAP_TICKS     = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Function codes and frame body lengths (address through data, in bytes)
  localparam logic [7:0] FC_RD_COILS  = 8'h01;
  localparam logic [7:0] FC_RD_INREGS = 8'h04;
  localparam logic [7:0] FC_WR_COIL   = 8'h05;
  localparam logic [7:0] FC_WR_REG    = 8'h06;
  localparam logic [7:0] FC_WR_COILS  = 8'h0f;
  localparam logic [7:0] FC_WR_REGS   = 8'h10;
  localparam logic [8:0] BODY_FIXED   = 9'h006;
  localparam logic [8:0] BODY_EXC     = 9'h003;
  localparam logic [8:0] BODY_RD_RESP = 9'h003;
  localparam logic [8:0] BODY_MULTI_Q = 9'h007;
  localparam logic [8:0] CRC_LEN      = 9'h002;
  localparam logic [8:0] LRC_LEN      = 9'h001;
  localparam logic [8:0] POS_ADDR     = 9'h000;
  localparam logic [8:0] POS_FC       = 9'h001;
  localparam logic [8:0] POS_BC_RESP  = 9'h002;
  localparam logic [8:0] POS_BC_QUERY = 9'h006;
  localparam logic [2:0] PACK_LAST    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer geometry
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;

  typedef struct packed {
    logic       is_bit;    // data[0] is one status point to be packed
    logic       pack_end;  // last status point of the group
    logic       last;      // last item of the frame body
    logic [7:0] data;
  } mbfc_tx_item_type;

  typedef struct packed {
    logic ok;
    logic error;
    logic exception;
    logic broadcast;
    logic respond;
  } mbfc_rx_status_type;

  typedef enum logic [1:0] {T_IDLE = 2'b00, T_BODY = 2'b01, T_CHK = 2'b11,
                            T_TAIL = 2'b10} mbfc_tx_state_type;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_BODY = 2'b01,
                            R_LF = 2'b11} mbfc_rx_state_type;

  function automatic logic [15:0] mbfc_crc_byte(input logic [15:0] crc,
                                                input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] mbfc_hex_char(input logic [3:0] v);
    return (v < 4'ha) ? HEX_DIGIT_OFS + {4'h0, v} : HEX_ALPHA_OFS + {4'h0, v};
  endfunction

endpackage

// ==== mbfc_codec_assertions.sv ====
// Port-level checker for the serial frame codec.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module mbfc_codec_chk
  import mbfc_pkg::*;
(
  input wire logic               mclk_in,
  input wire logic               rst_in,
  input wire logic               ascii_mode_in,
  input wire logic               resp_mode_in,
  input wire logic [7:0]         station_addr_in,
  input wire logic [7:0]         tx_char_out,
  input wire logic               tx_char_valid_out,
  input wire logic               tx_char_ready_in,
  input wire logic               rx_char_valid_in,
  input wire logic               char_tick_in,
  input wire logic               rx_done_out,
  input wire mbfc_rx_status_type rx_status_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic tx_open;
  wire  taken = tx_char_valid_out && tx_char_ready_in;

  // Text frames only: LF closes a frame, so the next taken character opens one
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tx_open <= 1'b0;
    else if (taken && ascii_mode_in)
      tx_open <= (tx_char_out != CH_LF);
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence cr_taken;
    taken && ascii_mode_in && (tx_char_out == CH_CR);
  endsequence
  sequence lf_next;
    ##[1:8] (tx_char_valid_out && (tx_char_out == CH_LF));
  endsequence

  chk_char_hold: assert property (tx_char_valid_out && !tx_char_ready_in
    |=> tx_char_valid_out && $stable(tx_char_out)) else $error("character changed before taken");
  chk_ascii_tail: assert property (cr_taken |-> lf_next)
    else $error("line feed does not follow carriage return");
  chk_colon_first: assert property (taken && ascii_mode_in && !tx_open
    |-> tx_char_out == CH_COLON) else $error("text frame opens without colon");
  chk_status_stands: assert property (!rx_done_out |-> $stable(rx_status_out))
    else $error("status changed outside frame end");
  chk_bad_silent: assert property (rx_done_out && rx_status_out.error
    |-> !rx_status_out.respond && !rx_status_out.ok) else $error("bad frame not discarded");
  chk_bcast_silent: assert property (rx_done_out && rx_status_out.broadcast
    |-> !rx_status_out.respond) else $error("broadcast asks for a reply");
  chk_respond_addr: assert property (rx_done_out && rx_status_out.respond
    |-> !resp_mode_in && station_addr_in != ADDR_BCAST && station_addr_in <= ADDR_MAX)
    else $error("reply flagged for a frame that needs none");
  chk_gap_end: assert property (rx_done_out && !ascii_mode_in |-> $past(char_tick_in))
    else $error("binary frame ended without idle gap");
  chk_text_end: assert property (rx_done_out && ascii_mode_in |-> $past(rx_char_valid_in))
    else $error("text frame ended without a character");
endmodule

bind mbfc_codec mbfc_codec_chk u_chk (.mclk_in, .rst_in, .ascii_mode_in, .resp_mode_in,
  .station_addr_in, .tx_char_out, .tx_char_valid_out, .tx_char_ready_in, .rx_char_valid_in,
  .char_tick_in, .rx_done_out, .rx_status_out);

// ==== mbfc_remote_station.sv ====
// Remote station model: frame builder, character sink and character source.
// Assumes the bench loads send_q and sets slow or hold between frames.
`timescale 1ns/100ps
package mbfc_vrf_pkg;
  import mbfc_pkg::*;
  typedef logic [7:0] mbfc_vrf_bytes_type[$];

  function automatic logic [7:0] vrf_hex(input logic [3:0] v);
    return (v > 4'h9) ? 8'h37 + {4'h0, v} : 8'h30 + {4'h0, v};
  endfunction

  // Whole frame in characters; bad spoils one bit of the check field
  function automatic mbfc_vrf_bytes_type vrf_frame(input mbfc_vrf_bytes_type b,
                                                   input logic asc, input logic bad);
    mbfc_vrf_bytes_type c;
    logic [15:0]        crc;
    logic [7:0]         lrc;
    crc = 16'hffff;
    lrc = 8'h00;
    foreach (b[i])
    begin
      lrc = lrc + b[i];
      crc = crc ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        crc = crc[0] ? ((crc >> 1) ^ 16'ha001) : (crc >> 1);
    end
    lrc = (~lrc + 8'h01) ^ {7'h00, bad};
    crc = crc ^ {15'h0000, bad};
    if (!asc)
      c = {b, crc[7:0], crc[15:8]};
    else
    begin
      c = {CH_COLON};
      foreach (b[i])
        c = {c, vrf_hex(b[i][7:4]), vrf_hex(b[i][3:0])};
      c = {c, vrf_hex(lrc[7:4]), vrf_hex(lrc[3:0]), CH_CR, CH_LF};
    end
    return c;
  endfunction
endpackage

////////////////////////////////////////////////////////////////////////////////
module mbfc_remote_station (
  output logic       tx_char_ready_out,
  output logic [7:0] rx_char_out,
  output logic       rx_char_valid_out,
  output logic       char_tick_out,
  input  wire logic  clk_in
);
  logic [7:0] send_q[$];
  logic       slow     = 1'b0;
  logic       hold     = 1'b0;
  logic [1:0] tick_cnt = 2'h0;

  initial
  begin
    tx_char_ready_out = 1'b1;
    rx_char_out       = 8'h00;
    rx_char_valid_out = 1'b0;
    char_tick_out     = 1'b0;
  end

  always @(negedge clk_in)
  begin
    tick_cnt          <= tick_cnt + 2'h1;
    char_tick_out     <= (tick_cnt == 2'h3);
    tx_char_ready_out <= !hold && (!slow || ($urandom_range(1, 0) == 1));
    if ((tick_cnt == 2'h3) && (send_q.size() != 0))
    begin
      rx_char_valid_out <= 1'b1;
      rx_char_out       <= send_q.pop_front();
    end
    else
    begin
      rx_char_valid_out <= 1'b0;
      // Idle line flips every bit each cycle, so it shows the last character every other cycle
      rx_char_out       <= ~rx_char_out;
    end
  end
endmodule

// ==== test_mbfc_codec.sv ====
// Self-checking bench for the frame codec; the remote station plays the far end.
// Assumes a 10 MHz clock; expected results queue up in order of appearance.
`timescale 1ns/100ps
module test_mbfc_codec
  import mbfc_pkg::*;
  import mbfc_vrf_pkg::*;
;
  logic               mclk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               ascii_mode_in = 1'b0;
  logic               resp_mode_in = 1'b0;
  logic [7:0]         station_addr_in = 8'h02;
  logic               tx_valid_in = 1'b0;
  mbfc_tx_item_type   tx_item_in = '0;
  logic               tx_ready_out, tx_char_valid_out, tx_char_ready_in;
  logic               rx_char_valid_in, char_tick_in, rx_byte_valid_out, rx_done_out;
  logic [7:0]         tx_char_out, rx_char_in, rx_byte_out;
  mbfc_rx_status_type rx_status_out;
  logic [9:0]         rx_expect_len_out;
  int                 fails = 0;
  int                 compares = 0;
  logic [7:0]         exp_tx[$], exp_rx[$];
  logic [15:0]        exp_st[$];
  mbfc_vrf_bytes_type q_query = '{8'h02, 8'h01, 8'h00, 8'h13, 8'h00, 8'h25};
  mbfc_vrf_bytes_type q_bits = '{8'h02, 8'h02, 8'h05, 8'hcd, 8'h6b, 8'hb2, 8'h0e, 8'h1b};
  mbfc_vrf_bytes_type q_big;

  mbfc_codec dut (.mclk_in, .rst_in, .ascii_mode_in, .resp_mode_in, .station_addr_in,
    .tx_valid_in, .tx_item_in, .tx_ready_out, .tx_char_out, .tx_char_valid_out,
    .tx_char_ready_in, .rx_char_in, .rx_char_valid_in, .char_tick_in, .rx_byte_out,
    .rx_byte_valid_out, .rx_done_out, .rx_status_out, .rx_expect_len_out);
  mbfc_remote_station u_station (.clk_in(mclk_in), .tx_char_ready_out(tx_char_ready_in),
    .rx_char_out(rx_char_in), .rx_char_valid_out(rx_char_valid_in),
    .char_tick_out(char_tick_in));

  initial
  begin
    forever #50 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk_in)
  begin
    if (!rst_in && tx_char_valid_out && tx_char_ready_in)
      check({8'h00, tx_char_out}, {8'h00, exp_tx.pop_front()});
    if (rx_byte_valid_out)
      check({8'h00, rx_byte_out}, {8'h00, exp_rx.pop_front()});
    if (rx_done_out)
      check({1'b0, rx_status_out, rx_expect_len_out}, exp_st.pop_front());
  end

  // Waits for all noted results, then one binary end-of-frame gap
  task automatic settle(input string name);
    int n;
    n = 0;
    while ((exp_tx.size() + exp_rx.size() + exp_st.size() != 0) && n < 3000)
    begin
      @(posedge mclk_in);
      n++;
    end
    check(16'(exp_tx.size() + exp_rx.size() + exp_st.size()), 16'h0000);
    repeat (4) @(posedge char_tick_in);
    @(posedge mclk_in);
    $display("test %s finished", name);
  endtask

  task automatic push_item(input logic b, input logic e, input logic l, input logic [7:0] d);
    @(negedge mclk_in);
    tx_valid_in = 1'b1;
    tx_item_in  = '{b, e, l, d};
    @(posedge mclk_in);
    while (!tx_ready_out)
      @(posedge mclk_in);
  endtask

  task automatic tx_frame(input mbfc_vrf_bytes_type b, input int hdr, input int nbits);
    exp_tx = {exp_tx, vrf_frame(b, ascii_mode_in, 1'b0)};
    for (int i = 0; i < hdr; i++)
      push_item(1'b0, 1'b0, (nbits == 0) && (i == hdr - 1), b[i]);
    for (int k = 0; k < nbits; k++)
      push_item(1'b1, k == nbits - 1, k == nbits - 1, {7'($urandom), b[hdr + k / 8][k % 8]});
    @(negedge mclk_in);
    tx_valid_in = 1'b0;
  endtask

  task automatic tx_case(input mbfc_vrf_bytes_type b, input logic asc, input int hdr,
                         input int nbits, input logic slow);
    @(negedge mclk_in);
    ascii_mode_in = asc;
    @(posedge mclk_in);
    u_station.slow = slow;
    tx_frame(b, hdr, nbits);
    settle("tx");
  endtask

  task automatic rx_case(input mbfc_vrf_bytes_type b, input logic asc, input logic resp,
                         input logic bad, input logic [4:0] st);
    mbfc_vrf_bytes_type c;
    @(negedge mclk_in);
    ascii_mode_in = asc;
    resp_mode_in  = resp;
    c = vrf_frame(b, asc, bad);
    foreach (c[i])
      if (asc && c[i] inside {[8'h41:8'h46]})
        c[i] = c[i] + 8'h20; // Lower-case hex digits must decode as well
    exp_rx = {exp_rx, b};
    exp_st.push_back({1'b0, st, 10'(c.size())});
    @(posedge mclk_in);
    u_station.send_q = {u_station.send_q, c};
    settle("rx");
  endtask

  initial
  begin
    repeat (30000) @(posedge mclk_in);
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h4508aa3a));
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    check({1'b0, rx_status_out, rx_expect_len_out}, 16'h0008);
    for (int m = 0; m < 4; m++)
      rx_case(q_query, m[1], 1'b0, m[0], m[0] ? 5'b01000 : 5'b10001);
    rx_case('{8'h00, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b0, 1'b0, 1'b0, 5'b10010);
    rx_case('{8'h07, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0, 1'b0, 5'b10000);
    rx_case('{8'h02, 8'h81, 8'h02}, 1'b1, 1'b1, 1'b0, 5'b10100);
    rx_case('{8'h02, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34}, 1'b0, 1'b1, 1'b0, 5'b10000);
    rx_case('{8'h02, 8'h01, 8'h02, 8'h5a, 8'h03}, 1'b1, 1'b1, 1'b0, 5'b10000);
    rx_case('{8'h02, 8'h03, 8'h04, 8'($urandom), 8'h01, 8'h02, 8'h03},
            1'b1, 1'b1, 1'b0, 5'b10000);
    rx_case('{8'h02, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h0a, 8'h02, 8'hff, 8'h03},
            1'b1, 1'b0, 1'b0, 5'b10001);
    rx_case('{8'h02, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'($urandom), 8'h00,
              8'h7f, 8'hff}, 1'b0, 1'b0, 1'b0, 5'b10001);
    tx_case(q_query, 1'b0, 6, 0, 1'b1);
    tx_case(q_query, 1'b1, 6, 0, 1'b0);
    tx_case(q_bits, 1'b0, 3, 37, 1'b1);
    tx_case(q_bits, 1'b1, 3, 37, 1'b0);
    for (int i = 0; i < 24; i++)
      q_big.push_back(8'($urandom));
    u_station.hold = 1'b1;
    fork
      tx_frame(q_big, 24, 0);
    join_none
    repeat (40) @(posedge mclk_in);
    check({15'h0000, tx_ready_out}, 16'h0000); // Full buffer refuses items
    u_station.hold = 1'b0;
    settle("buffer");
    tally_and_finish();
  end
endmodule
